// ### hw/hrsld_top.sv
// Purpose: reference switching, holdover control, DAC control and lock detect
// Assumes: all inputs synchronous to CORE_CLK; comparison strobes are one-cycle pulses
// Notes: one clock; the DAC update rate is a one-cycle enable from a divider
`timescale 1ns/1ps
`include "hrsld_params.svh"
module hrsld_top
  import hrsld_pkg::*;
#(
  parameter int DAC_W = `HRSLD_DAC_W,
  parameter int CNT_W = `HRSLD_CNT_W
) (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic [3:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire logic REF_SELECT_PIN0,
  input wire logic REF_SELECT_PIN1,
  input wire logic PD1_STROBE,
  input wire logic PD1_IN_WINDOW,
  input wire logic SECOND_LOOP_LOCK_IN,
  input wire logic [DAC_W-1:0] TUNE_LEVEL,
  output logic [1:0] ACTIVE_REF,
  output logic HOLDOVER,
  output logic FIRST_LOOP_LOCK,
  output logic SECOND_LOOP_LOCK,
  output logic PUMP_TRISTATE,
  output logic [DAC_W-1:0] DAC_VALUE,
  output logic DAC_DRIVE,
  output logic DAC_RAIL,
  output logic LOCK_STATUS_PIN,
  output logic HOLDOVER_STATUS_PIN
);
  hrsld_bus_type bus;
  assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

  logic [31:0] ctrl_q;
  logic [DAC_W-1:0] manual_dac_value_q;
  logic [DAC_W-1:0] trip_lo_q;
  logic [DAC_W-1:0] trip_hi_q;
  logic [CNT_W-1:0] win_q;
  logic [CNT_W-1:0] lock_thr_q;
  logic [13:0] div1r_q;
  logic [13:0] div1n_q;
  logic [11:0] div2r_q;
  logic [17:0] div2n_q;
  logic hold_wr_dis;

  // host writes; disabling holdover does not clear the force bit, which still forces holdover
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_q <= 32'h00000000;
      manual_dac_value_q <= `HRSLD_DAC_MID;
      trip_lo_q <= '0;
      trip_hi_q <= '1;
      win_q <= '0;
      lock_thr_q <= '1;
      div1r_q <= 14'h0001;
      div1n_q <= 14'h0001;
      div2r_q <= 12'h001;
      div2n_q <= 18'h00001;
    end else if (bus.wr) begin
      case (bus.addr)
        `HRSLD_A_CTRL: ctrl_q <= bus.wdata;
        `HRSLD_A_DAC: manual_dac_value_q <= bus.wdata[DAC_W-1:0];
        `HRSLD_A_TRIP: begin
          trip_lo_q <= bus.wdata[DAC_W-1:0];
          trip_hi_q <= bus.wdata[DAC_W+15:16];
        end
        `HRSLD_A_LOCK: begin
          win_q <= bus.wdata[CNT_W-1:0];
          lock_thr_q <= bus.wdata[CNT_W+15:16];
        end
        `HRSLD_A_DIV1: begin
          div1r_q <= bus.wdata[13:0];
          div1n_q <= bus.wdata[29:16];
        end
        `HRSLD_A_DIV2R: div2r_q <= bus.wdata[11:0];
        `HRSLD_A_DIV2N: div2n_q <= bus.wdata[17:0];
        default: ;
      endcase
    end
  end

  assign hold_wr_dis = bus.wr && (bus.addr == `HRSLD_A_CTRL)
    && (bus.wdata[`HRSLD_C_HOLD] == `HRSLD_HOLD_DISABLED);

  logic [2:0] sel_mode;
  logic hold_en;
  logic force_hold;
  logic dld_dis;
  logic rail_en;
  logic track_en;
  logic man_en;
  logic [15:0] dac_div;
  assign sel_mode = ctrl_q[`HRSLD_C_MODE];
  assign hold_en = ctrl_q[`HRSLD_C_HOLD] == `HRSLD_HOLD_ENABLED;
  assign force_hold = ctrl_q[`HRSLD_C_FORCE];
  assign dld_dis = ctrl_q[`HRSLD_C_DLDDIS];
  // tracked mode with rail detect is invalid, so rail detect needs manual DAC
  assign rail_en = ctrl_q[`HRSLD_C_RAILEN] && ctrl_q[`HRSLD_C_MAN];
  assign track_en = ctrl_q[`HRSLD_C_TRACK];
  assign man_en = ctrl_q[`HRSLD_C_MAN];
  assign dac_div = ctrl_q[`HRSLD_C_DACDIV];

  // lock detector
  logic [CNT_W-1:0] lock_cnt_q;
  logic lock_q;
  logic hold_go;
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      lock_cnt_q <= '0;
      lock_q <= 1'b0;
    end else if (hold_go) begin
      // restart on entry: a stale lock would otherwise pin the state in holdover
      lock_cnt_q <= '0;
      lock_q <= 1'b0;
    end else if (PD1_STROBE) begin
      if (!PD1_IN_WINDOW) begin
        lock_cnt_q <= '0;
        lock_q <= 1'b0;
      end else if (!lock_q) begin
        if (lock_cnt_q + 1'b1 >= lock_thr_q) begin
          lock_q <= 1'b1;
        end
        lock_cnt_q <= lock_cnt_q + 1'b1;
      end
    end
  end

  // select pin decode
  logic p0;
  logic p1;
  logic [1:0] pin_ref;
  assign p0 = REF_SELECT_PIN0 ^ ctrl_q[`HRSLD_C_INV];
  assign p1 = REF_SELECT_PIN1 ^ ctrl_q[`HRSLD_C_INV];
  assign pin_ref = p0 ? 2'h0 : (p1 ? 2'h1 : 2'h2);

  logic [1:0] pins_q;
  logic armed_q;
  logic lock_prev_q;
  logic pin_change;
  logic lock_fall;
  logic rail_hit;
  logic dac_low;
  logic dac_high;
  logic switch_ev;
  assign pin_change = pins_q != {p1, p0};
  assign lock_fall = lock_prev_q && !lock_q && !dld_dis;
  assign dac_low = TUNE_LEVEL <= trip_lo_q;
  assign dac_high = TUNE_LEVEL >= trip_hi_q;
  assign rail_hit = rail_en && (dac_low || dac_high);
  // a further event is ignored until lock has been regained
  assign switch_ev = (sel_mode == `HRSLD_MODE_AUTO_PIN) && armed_q
    && (pin_change || lock_fall);

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pins_q <= 2'h0;
      lock_prev_q <= 1'b0;
      armed_q <= 1'b1;
    end else begin
      pins_q <= {p1, p0};
      lock_prev_q <= lock_q;
      if (switch_ev) begin
        armed_q <= 1'b0;
      end else if (lock_q) begin
        armed_q <= 1'b1;
      end
    end
  end

  // active reference and holdover state
  hrsld_state_type st_q;
  logic [1:0] ref_q;
  logic enter_hold;
  assign enter_hold = hold_en && ((switch_ev)
    || (lock_fall)
    || rail_hit);
  assign hold_go = (st_q == HRSLD_RUN) && (force_hold || enter_hold);
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_q <= HRSLD_RUN;
      ref_q <= 2'h0;
    end else begin
      if (switch_ev) begin
        ref_q <= pin_ref;
      end else if (sel_mode < 3'h3) begin
        ref_q <= sel_mode[1:0];
      end
      case (st_q)
        HRSLD_RUN: begin
          if (force_hold || enter_hold) begin
            st_q <= HRSLD_HOLD;
          end
        end
        HRSLD_HOLD, HRSLD_WAIT_LOCK: begin
          if (hold_wr_dis) begin
            st_q <= HRSLD_RUN;
          end else if (force_hold) begin
            st_q <= HRSLD_HOLD;
          end else if (st_q == HRSLD_HOLD) begin
            if (!lock_q && !rail_hit) begin
              st_q <= HRSLD_WAIT_LOCK;
            end
          end else if (lock_q && !rail_hit) begin
            st_q <= HRSLD_RUN;
          end
        end
        default: st_q <= HRSLD_RUN;
      endcase
    end
  end

  // DAC update enable from the divided phase detector rate
  logic [15:0] dac_count_readback_q;
  logic dac_tick;
  logic [DAC_W-1:0] track_q;
  assign dac_tick = PD1_STROBE && (dac_count_readback_q + 16'h0001 >= dac_div);
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      dac_count_readback_q <= 16'h0000;
    end else if (PD1_STROBE) begin
      dac_count_readback_q <= dac_tick ? 16'h0000 : dac_count_readback_q + 16'h0001;
    end
  end

  // tracking freezes in holdover so the last valid value is kept
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      track_q <= `HRSLD_DAC_MID;
    end else if (track_en && dac_tick && (st_q == HRSLD_RUN)) begin
      track_q <= TUNE_LEVEL;
    end
  end

  logic in_hold;
  logic first_lock;
  logic lock_sel;
  logic hold_sel;
  assign in_hold = st_q != HRSLD_RUN;
  assign first_lock = lock_q && !in_hold;
  function automatic logic mux_pick(input logic [1:0] s, input logic l1, input logic l2,
                                    input logic h);
    case (s)
      `HRSLD_MUX_FIRST: mux_pick = l1;
      `HRSLD_MUX_SECOND: mux_pick = l2;
      `HRSLD_MUX_BOTH: mux_pick = l1 && l2;
      default: mux_pick = h;
    endcase
  endfunction
  assign lock_sel = mux_pick(ctrl_q[`HRSLD_C_LDMUX], first_lock, SECOND_LOOP_LOCK_IN,
    in_hold);
  assign hold_sel = mux_pick(ctrl_q[`HRSLD_C_HOMUX], first_lock, SECOND_LOOP_LOCK_IN,
    in_hold);

  // output flops
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ACTIVE_REF <= 2'h0;
      HOLDOVER <= 1'b0;
      FIRST_LOOP_LOCK <= 1'b0;
      SECOND_LOOP_LOCK <= 1'b0;
      PUMP_TRISTATE <= 1'b0;
      DAC_DRIVE <= 1'b0;
      DAC_VALUE <= `HRSLD_DAC_MID;
      DAC_RAIL <= 1'b0;
      LOCK_STATUS_PIN <= 1'b0;
      HOLDOVER_STATUS_PIN <= 1'b0;
    end else begin
      ACTIVE_REF <= ref_q;
      HOLDOVER <= in_hold;
      FIRST_LOOP_LOCK <= first_lock;
      SECOND_LOOP_LOCK <= SECOND_LOOP_LOCK_IN;
      PUMP_TRISTATE <= in_hold;
      DAC_DRIVE <= in_hold;
      DAC_VALUE <= (man_en || !track_en) ? manual_dac_value_q : track_q;
      DAC_RAIL <= dac_low || dac_high;
      LOCK_STATUS_PIN <= lock_sel;
      HOLDOVER_STATUS_PIN <= hold_sel;
    end
  end

  // read port, data in the cycle after the strobe
  hrsld_stat_type stat;
  assign stat = '{holdover: in_hold, first_lock: first_lock, rail: dac_low || dac_high,
    dac_low: dac_low, dac_high: dac_high, active_ref: ref_q};
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      RDATA <= 32'h00000000;
    end else if (bus.rd) begin
      case (bus.addr)
        `HRSLD_A_CTRL: RDATA <= ctrl_q;
        `HRSLD_A_DAC: RDATA <= 32'(manual_dac_value_q);
        `HRSLD_A_TRIP: RDATA <= {6'h00, trip_hi_q, 6'h00, trip_lo_q};
        `HRSLD_A_LOCK: RDATA <= {2'h0, lock_thr_q, 2'h0, win_q};
        `HRSLD_A_DIV1: RDATA <= {2'h0, div1n_q, 2'h0, div1r_q};
        `HRSLD_A_DIV2R: RDATA <= {20'h00000, div2r_q};
        `HRSLD_A_DIV2N: RDATA <= {14'h0000, div2n_q};
        `HRSLD_A_STAT: RDATA <= {25'h0000000, stat};
        `HRSLD_A_DACRB: RDATA <= 32'(track_q);
        default: RDATA <= 32'h00000000;
      endcase
    end else begin
      RDATA <= 32'h00000000;
    end
  end
endmodule // hrsld_top

// ### common/hrsld_params.svh
// Purpose: constants for the holdover, reference switch and lock detect block
// Assumes: included by the package and by the design file
// Notes: all timing is in CORE_CLK cycles unless stated
// Contract
// - mode six picks reference from select pins
// - switch with holdover: enter holdover, take pins
// - leave holdover on exit condition, keep reference
// - no holdover: switch directly, keep reference
// - lock must return before next switch honoured
// - rail crossing with detect enters holdover
// - rail flag is low or high flag
// - invert bit flips both select pins
// - holdover tri-states pump, drives DAC voltage
// - holdover needs enable; force bit forces it
// - fixed and tracked holdover sub-modes
// - tracked DAC updates at divided detector rate
// - enable two and lock loss enters holdover
// - holdover drops first lock, keeps second lock
// - holdover DAC value manual or last tracked
// - holdover status routable to either status pin
// - writing enable disabled leaves holdover
// - first loop lock success exits holdover
// - count in-window comparisons, lock at threshold
// - one out-of-window comparison drops lock
// - lock pins show first, second or both
// - first loop dividers up to 16383
// - second loop dividers up to 4095 and 262143
`ifndef HRSLD_PARAMS_SVH
`define HRSLD_PARAMS_SVH

`define HRSLD_MODE_AUTO_PIN 3'h6
`define HRSLD_HOLD_DISABLED 2'h0
`define HRSLD_HOLD_ENABLED 2'h2
`define HRSLD_MUX_FIRST 2'h0
`define HRSLD_MUX_SECOND 2'h1
`define HRSLD_MUX_BOTH 2'h2
`define HRSLD_MUX_HOLD 2'h3
`define HRSLD_FIRST_LOOP_DIV_MAX 14'h3fff
`define HRSLD_SECOND_LOOP_R_MAX 12'hfff
`define HRSLD_SECOND_LOOP_N_MAX 18'h3ffff
`define HRSLD_DAC_W 10
`define HRSLD_DAC_MID 10'h200
`define HRSLD_CNT_W 14

// register indices on the plain port
`define HRSLD_A_CTRL 4'h0
`define HRSLD_A_DAC 4'h1
`define HRSLD_A_TRIP 4'h2
`define HRSLD_A_LOCK 4'h3
`define HRSLD_A_DIV1 4'h4
`define HRSLD_A_DIV2R 4'h5
`define HRSLD_A_DIV2N 4'h6
`define HRSLD_A_STAT 4'h7
`define HRSLD_A_DACRB 4'h8

// control register fields
`define HRSLD_C_MODE 2:0
`define HRSLD_C_INV 3
`define HRSLD_C_HOLD 5:4
`define HRSLD_C_FORCE 6
`define HRSLD_C_DLDDIS 7
`define HRSLD_C_RAILEN 8
`define HRSLD_C_TRACK 9
`define HRSLD_C_MAN 10
`define HRSLD_C_LDMUX 12:11
`define HRSLD_C_HOMUX 14:13
`define HRSLD_C_DACDIV 30:15

`endif

// ### common/hrsld_pkg.sv
// Purpose: shared types for the holdover, reference switch and lock detect block
// Assumes: hrsld_params.svh defines widths
// Notes: structs carry the bus port and status groups
`include "hrsld_params.svh"
package hrsld_pkg;
  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } hrsld_bus_type;

  typedef struct packed {
    logic holdover;
    logic first_lock;
    logic rail;
    logic dac_low;
    logic dac_high;
    logic [1:0] active_ref;
  } hrsld_stat_type;

  typedef enum logic [1:0] {
    HRSLD_RUN,
    HRSLD_HOLD,
    HRSLD_WAIT_LOCK
  } hrsld_state_type;
endpackage

// ### tb/hrsld_host_model.sv
// Purpose: host side model driving select pins and comparison strobes
// Assumes: one strobe every fourth CORE_CLK cycle while run is high
// Notes: window level is meaningless between strobes, so it toggles there
`timescale 1ns/1ps
module hrsld_host_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] sel,
  input wire logic win,
  input wire logic run,
  output logic pin0,
  output logic pin1,
  output logic strobe,
  output logic in_win
);
  logic [1:0] ph_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {pin1, pin0} <= 2'h0;
      ph_q <= 2'h0;
      strobe <= 1'b0;
      in_win <= 1'b0;
    end else begin
      {pin1, pin0} <= sel;
      ph_q <= ph_q + 2'h1;
      strobe <= run && ph_q == 2'h3;
      in_win <= (run && ph_q == 2'h3) ? win : ~in_win;
    end
  end
endmodule // hrsld_host_model

// ### tb/hrsld_checker_properties.sv
// Purpose: port level temporal checks of hrsld_top
// Assumes: one clock domain, RST_N asynchronous active low
// Notes: control word shadowed from the write port; settled after 6 cycles
`timescale 1ns/1ps
module hrsld_checker_properties #(
  parameter int DAC_W = 10,
  parameter int CNT_W = 14
) (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic [3:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [31:0] RDATA,
  input wire logic REF_SELECT_PIN0,
  input wire logic REF_SELECT_PIN1,
  input wire logic PD1_STROBE,
  input wire logic PD1_IN_WINDOW,
  input wire logic SECOND_LOOP_LOCK_IN,
  input wire logic [1:0] ACTIVE_REF,
  input wire logic HOLDOVER,
  input wire logic FIRST_LOOP_LOCK,
  input wire logic SECOND_LOOP_LOCK,
  input wire logic PUMP_TRISTATE,
  input wire logic DAC_DRIVE
);
  logic [31:0] ctrl_q;
  logic [2:0] age_q;
  wire logic [1:0] sp = {REF_SELECT_PIN1, REF_SELECT_PIN0} ^ {2{ctrl_q[3]}};
  wire logic [1:0] pin_ref = sp[0] ? 2'h0 : (sp[1] ? 2'h1 : 2'h2);
  // age stays zero until the first control write: reset contents unknown here
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_q <= 32'h0;
      age_q <= 3'h0;
    end else if (WR && ADDR == 4'h0) begin
      ctrl_q <= WDATA;
      age_q <= 3'h1;
    end else if (age_q != 3'h0 && age_q != 3'h7) begin
      age_q <= age_q + 3'h1;
    end
  end
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  sequence s_switch;
    age_q == 3'h7 && ctrl_q[2:0] == 3'h6 && !ctrl_q[6] && FIRST_LOOP_LOCK && !HOLDOVER
      && !$stable({REF_SELECT_PIN1, REF_SELECT_PIN0});
  endsequence
  AST_SWITCH_HOLD: assert property (s_switch ##0 ctrl_q[5:4] == 2'h2
    |-> ##[1:3] (HOLDOVER && ACTIVE_REF == pin_ref)) else $error("switch missed holdover");
  AST_SWITCH_DIRECT: assert property (s_switch ##0 ctrl_q[5:4] == 2'h0
    |-> ##[1:3] (!HOLDOVER && ACTIVE_REF == pin_ref)) else $error("direct switch wrong");
  AST_HOLD_PUMP: assert property (HOLDOVER [*2] |-> PUMP_TRISTATE && DAC_DRIVE)
    else $error("pump not released in holdover");
  AST_HOLD_LOCK: assert property (HOLDOVER [*2] |-> !FIRST_LOOP_LOCK)
    else $error("first lock high in holdover");
  AST_SECOND_LOCK: assert property (SECOND_LOOP_LOCK == $past(SECOND_LOOP_LOCK_IN))
    else $error("second lock not followed");
  AST_RAIL_FLAG: assert property ($past(RD) && $past(ADDR) == 4'h7
    |-> RDATA[4] == (RDATA[3] || RDATA[2])) else $error("rail flag mismatch");
  AST_LOCK_DROP: assert property (FIRST_LOOP_LOCK && PD1_STROBE && !PD1_IN_WINDOW
    |-> ##2 !FIRST_LOOP_LOCK) else $error("lock kept after miss");
  AST_FORCE: assert property (age_q == 3'h7 && ctrl_q[6] |-> HOLDOVER)
    else $error("force ignored");
  AST_EXIT: assert property (WR && ADDR == 4'h0 && WDATA[6:4] == 3'h0
    |-> ##[1:4] !HOLDOVER) else $error("holdover kept after disable");
endmodule // hrsld_checker_properties
bind hrsld_top hrsld_checker_properties #(.DAC_W(DAC_W), .CNT_W(CNT_W)) chk_inst (
  .CORE_CLK(CORE_CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
  .RDATA(RDATA), .REF_SELECT_PIN0(REF_SELECT_PIN0), .REF_SELECT_PIN1(REF_SELECT_PIN1),
  .PD1_STROBE(PD1_STROBE), .PD1_IN_WINDOW(PD1_IN_WINDOW),
  .SECOND_LOOP_LOCK_IN(SECOND_LOOP_LOCK_IN), .ACTIVE_REF(ACTIVE_REF), .HOLDOVER(HOLDOVER),
  .FIRST_LOOP_LOCK(FIRST_LOOP_LOCK), .SECOND_LOOP_LOCK(SECOND_LOOP_LOCK),
  .PUMP_TRISTATE(PUMP_TRISTATE), .DAC_DRIVE(DAC_DRIVE));

// ### tb/tb_top.sv
// Purpose: self-checking bench of hrsld_top
// Assumes: 20 MHz clock, host model makes pins and strobes
// Notes: random values from a fixed seed, corners by hand
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fail_count++; \
  $display("Error at %0t: got %h expected %h", $time, a, b); end end
module tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic sl2 = 1'b0;
  logic [9:0] tune = 10'h200;
  logic [1:0] sel = 2'h0;
  logic win = 1'b1;
  logic run = 1'b0;
  logic [31:0] rdata;
  logic [1:0] aref;
  logic [9:0] dac, man;
  logic hold, l1, l2, pump, ddrv, rail, lpin, hpin, p0, p1, stb, inw, inv;
  logic [1:0] nsel;
  int n;
  integer seed = 15567;
  int fail_count = 0;
  int cmp_count = 0;
  always #25 clk = ~clk;
  hrsld_host_model hrsld_host_model_inst (.clk(clk), .rst_n(rst_n), .sel(sel), .win(win),
    .run(run), .pin0(p0), .pin1(p1), .strobe(stb), .in_win(inw));
  hrsld_top hrsld_top_inst (.CORE_CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .REF_SELECT_PIN0(p0), .REF_SELECT_PIN1(p1),
    .PD1_STROBE(stb), .PD1_IN_WINDOW(inw), .SECOND_LOOP_LOCK_IN(sl2), .TUNE_LEVEL(tune),
    .ACTIVE_REF(aref), .HOLDOVER(hold), .FIRST_LOOP_LOCK(l1), .SECOND_LOOP_LOCK(l2),
    .PUMP_TRISTATE(pump), .DAC_VALUE(dac), .DAC_DRIVE(ddrv), .DAC_RAIL(rail),
    .LOCK_STATUS_PIN(lpin), .HOLDOVER_STATUS_PIN(hpin));
  // f = {manual, track, rail, lock loss off, force}, m = {holdover mux, lock mux}
  function automatic logic [31:0] cw(input logic i, input logic [1:0] h, input logic [4:0] f,
    input logic [3:0] m);
    return {1'b0, 16'd50, m, f, h, i, 3'h6};
  endfunction
  function automatic logic [1:0] xref(input logic [1:0] s, input logic i);
    s = s ^ {i, i};
    return s[0] ? 2'h0 : (s[1] ? 2'h1 : 2'h2);
  endfunction
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK(rdata, e)
  endtask
  task automatic settle(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  // lock regained and holdover left, bounded
  task automatic lockw();
    for (int i = 0; i < 400 && (l1 !== 1'b1 || hold !== 1'b0); i++) settle(1);
    settle(1);
  endtask
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #2000000;
    fail_count++;
    summarize();
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    settle(1);
    `CHK({hold, pump, dac}, {2'h0, 10'h200})
    man = 10'($random(seed));
    wreg(4'h1, {22'h0, man});
    rchk(4'h1, {22'h0, man});
    wreg(4'h4, {2'h0, 14'h3fff, 2'h0, 14'h3fff});
    rchk(4'h4, {2'h0, 14'h3fff, 2'h0, 14'h3fff});
    wreg(4'h5, 32'hfff);
    rchk(4'h5, 32'hfff);
    wreg(4'h6, 32'h3ffff);
    rchk(4'h6, 32'h3ffff);
    rchk(4'hf, 32'h0);
    $display("test registers done");
    wreg(4'h3, {2'h0, 14'd3, 2'h0, 14'd9});
    @(posedge clk);
    run <= 1'b1;
    sl2 <= 1'b1;
    n = 0;
    for (int i = 0; i < 200 && l1 !== 1'b1; i++) begin
      settle(1);
      if (stb === 1'b1) n++;
    end
    `CHK(n, 3)
    @(posedge clk);
    win <= 1'b0;
    settle(8);
    `CHK(l1, 1'b0)
    @(posedge clk);
    win <= 1'b1;
    lockw();
    $display("test lock done");
    for (int k = 0; k < 8; k++) begin
      inv = 1'($random(seed));
      wreg(4'h0, cw(inv, {k[0], 1'b0}, 5'h12, 4'h0));
      // an invert change is itself a switch; wait until lock is back before the pins move
      settle(2);
      lockw();
      nsel = 2'($random(seed));
      if (nsel === sel) nsel = ~sel;
      @(posedge clk);
      run <= 1'b0;
      sel <= nsel;
      settle(6);
      `CHK(aref, xref(nsel, inv))
      `CHK({hold, pump, ddrv}, {3{k[0]}})
      if (k[0]) `CHK(dac, man)
      if (k[0]) begin
        @(posedge clk);
        sel <= ~nsel;
        settle(6);
        `CHK(aref, xref(nsel, inv))
      end
      @(posedge clk);
      run <= 1'b1;
      lockw();
      `CHK({hold, aref}, {1'b0, xref(nsel, inv)})
    end
    $display("test switch done");
    @(posedge clk);
    tune <= 10'($random(seed));
    wreg(4'h0, cw(1'b0, 2'h2, 5'h0a, 4'h0));
    settle(300);
    rchk(4'h8, {22'h0, tune});
    wreg(4'h0, cw(1'b0, 2'h2, 5'h0b, 4'h0));
    settle(6);
    `CHK({hold, dac}, {1'b1, tune})
    wreg(4'h0, cw(1'b0, 2'h0, 5'h0a, 4'h0));
    settle(6);
    `CHK(hold, 1'b0)
    $display("test holdover modes done");
    wreg(4'h0, cw(1'b0, 2'h2, 5'h10, 4'hd));
    lockw();
    `CHK(lpin, 1'b1)
    @(posedge clk);
    win <= 1'b0;
    settle(12);
    `CHK({hold, l2, hpin}, 3'h7)
    @(posedge clk);
    win <= 1'b1;
    lockw();
    `CHK(hold, 1'b0)
    $display("test lock loss done");
    wreg(4'h2, {6'h0, 10'h300, 6'h0, 10'h100});
    wreg(4'h0, cw(1'b0, 2'h2, 5'h16, 4'h0));
    @(posedge clk);
    tune <= 10'h3ff;
    settle(8);
    `CHK({hold, rail}, 2'h3)
    rchk(4'h7, {25'h0, 5'h15, aref});
    $display("test rail done");
    summarize();
  end
endmodule // tb_top
